// [hdl/adc_output_demux.sv]
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: Encode each sample to 8 bits, feed splitter.
// RULE2: Output codes are offset binary.
// RULE3: Split enable high activates 1:2 splitter.
// RULE4: Rate select picks dual or decimated mode.
// RULE5: Data changes on word clock rising edge.
// RULE6: Single mode: secondary repeats primary, one sample later.
// RULE7: Single mode carries every sample up to 500Msps.
// RULE8: Split modes deliver up to 500Msps per port.
// RULE9: Secondary unpowered: both lines of every bit high.
// RULE10: Splitter reset aligns phase, echoed on reset output.
// RULE11: Encoding errors stay within one step.
// RULE12: Dual mode: newer on primary, older on secondary.
// RULE13: Decimated mode drops alternate samples, quarter rate ports.
// RULE14: Single mode overrange follows primary sample only.
// RULE15: Split modes overrange from either port.
// RULE16: Overrange changes with its data words.
module adc_output_demux #(
  parameter int LEVELS = adc_split_pkg::LEVELS
) (
  input  wire logic              aclk,                      // System clock.
  input  wire logic              aresetn,                   // Synchronous reset, active low.
  // AXI4-Lite slave.
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Quantizer side, all asynchronous to aclk.
  input  wire logic              sample_clock,              // Sampling clock from the link.
  input  wire logic [LEVELS-1:0] comparator_levels,         // Thermometer from the comparators.
  input  wire logic              comparator_over,           // Input beyond full scale.
  input  wire logic              split_reset_in,            // Splitter phase reset pin.
  // Output port towards the capture logic.
  output logic [7:0]             primary_data_p,
  output logic [7:0]             primary_data_n,
  output logic [7:0]             secondary_data_p,
  output logic [7:0]             secondary_data_n,
  output logic                   output_word_clock_p,
  output logic                   output_word_clock_n,
  output logic                   overrange_p,
  output logic                   overrange_n,
  output logic                   split_reset_out_p,
  output logic                   split_reset_out_n,
  output logic                   irq                        // Level interrupt, active high.
);

  // Whole state of the block.
  typedef struct packed {
    logic [LEVELS-1:0]                         thr_s1;      // First synchroniser stage.
    logic [LEVELS-1:0]                         thr_s2;      // Second synchroniser stage.
    logic                                      ovr_s1;
    logic                                      ovr_s2;
    logic                                      clk_s1;
    logic                                      clk_s2;
    logic                                      clk_s3;      // Delayed copy for edge finding.
    logic                                      rst_s1;
    logic                                      rst_s2;
    adc_split_pkg::ctrl_t                      ctrl;
    logic [adc_split_pkg::IRQ_WIDTH-1:0]       irq_status;
    logic [adc_split_pkg::IRQ_WIDTH-1:0]       irq_mask;
    logic [1:0]                                phase;       // Splitter phase.
    adc_split_pkg::sample_t                    held;        // Older sample awaiting its pair.
    adc_split_pkg::sample_t                    prim;        // Primary port word.
    adc_split_pkg::sample_t                    sec;         // Secondary port word.
    logic                                      owc;         // Output word clock.
    logic                                      ovr_out;     // Overrange output.
    logic                                      rst_out;     // Reset echo.
    logic                                      aw_held;
    logic [7:0]                                awaddr;
    logic                                      w_held;
    logic [31:0]                               wdata;
    logic [3:0]                                wstrb;
    logic                                      bvalid;
    logic [1:0]                                bresp;
    logic                                      rvalid;
    logic [31:0]                               rdata;
    logic [1:0]                                rresp;
  } state_t;

  state_t                    state_reg;                     // Registered state.
  state_t                    state_next;                    // Next state.
  logic [7:0]                enc_code;                      // Encoded synchronised sample.
  adc_split_pkg::split_mode_t mode;                         // Mode from the control bits.
  logic                      sec_powered;                   // Secondary drivers alive.

  // Encoder works on the synchronised thermometer.
  thermo_encoder #(
    .LEVELS (LEVELS),
    .WIDTH  (adc_split_pkg::CODE_WIDTH)
  ) u_encoder (
    .levels (state_reg.thr_s2),
    .code   (enc_code)
  );

  // Mode decode from the two static control bits.
  always_comb begin
    // RULE3 splitter enable
    if (!state_reg.ctrl.split_enable) begin
      mode = adc_split_pkg::SINGLE_PORT_MODE;
    // RULE4 rate select
    end else if (state_reg.ctrl.rate_select) begin
      mode = adc_split_pkg::DECIMATED_MODE;
    end else begin
      mode = adc_split_pkg::DUAL_PORT_MODE;
    end
    sec_powered = state_reg.ctrl.power_a & state_reg.ctrl.power_b;
  end

  // Next-state logic for sampling, splitting, registers and the bus.
  always_comb begin
    adc_split_pkg::sample_t          smp;
    logic                            rise;
    logic                            rst_req;
    logic [adc_split_pkg::IRQ_WIDTH-1:0] irq_set;
    logic [adc_split_pkg::IRQ_WIDTH-1:0] irq_clr;
    logic                            do_write;
    smp        = '0;
    rise       = 1'b0;
    rst_req    = 1'b0;
    irq_set    = '0;
    irq_clr    = '0;
    do_write   = 1'b0;
    state_next = state_reg;

    // Two-flop synchronisers on every asynchronous input.
    state_next.thr_s1 = comparator_levels;
    state_next.thr_s2 = state_reg.thr_s1;
    state_next.ovr_s1 = comparator_over;
    state_next.ovr_s2 = state_reg.ovr_s1;
    state_next.clk_s1 = sample_clock;
    state_next.clk_s2 = state_reg.clk_s1;
    state_next.clk_s3 = state_reg.clk_s2;
    state_next.rst_s1 = split_reset_in;
    state_next.rst_s2 = state_reg.rst_s1;

    // Edges of the sample clock, seen after synchronisation.
    rise    = state_reg.clk_s2 & ~state_reg.clk_s3;
    rst_req = state_reg.rst_s2 | state_reg.ctrl.soft_reset;
    // RULE1 encode into 8 bits
    smp.code = enc_code;
    smp.over = state_reg.ovr_s2;

    // Single mode holds the word clock low while the sample clock is low.
    // This also clears a word clock left high by a split mode, so the next word gets a rising edge.
    if (!state_reg.clk_s2 && mode == adc_split_pkg::SINGLE_PORT_MODE) begin
      state_next.owc = 1'b0;
    end

    // Splitter acts once per sample.
    if (rise) begin
      // RULE10 phase reset echoed
      state_next.rst_out = rst_req;
      if (rst_req && !state_reg.rst_out) begin
        irq_set[adc_split_pkg::IRQ_RESET_BIT] = 1'b1;
      end
      unique case (mode)
        adc_split_pkg::SINGLE_PORT_MODE: begin
          // RULE7 every sample forwarded
          state_next.prim = smp;
          // RULE6 secondary lags one sample
          state_next.sec  = state_reg.prim;
          // RULE14 primary flag only
          state_next.ovr_out = smp.over;
          // RULE5 word clock rises with data
          state_next.owc   = 1'b1;
          state_next.phase = 2'h0;
          irq_set[adc_split_pkg::IRQ_OVERRANGE_BIT] = smp.over;
        end
        adc_split_pkg::DUAL_PORT_MODE: begin
          if (rst_req || !state_reg.phase[0]) begin
            // Older sample waits for its partner.
            state_next.held  = smp;
            state_next.owc   = 1'b0;
            state_next.phase = 2'h1;
          end else begin
            // RULE12 newer on primary
            state_next.prim = smp;
            state_next.sec  = state_reg.held;
            // RULE15 either port flags
            state_next.ovr_out = smp.over | state_reg.held.over;
            // RULE8 half rate per port
            state_next.owc   = 1'b1;
            state_next.phase = 2'h0;
            irq_set[adc_split_pkg::IRQ_OVERRANGE_BIT] = smp.over | state_reg.held.over;
          end
        end
        adc_split_pkg::DECIMATED_MODE: begin
          // RULE13 keep alternate samples
          if (rst_req || state_reg.phase == 2'h0) begin
            state_next.held  = smp;
            state_next.owc   = 1'b0;
            state_next.phase = 2'h1;
          end else if (state_reg.phase == 2'h2) begin
            state_next.prim    = smp;
            state_next.sec     = state_reg.held;
            // RULE16 flag moves with words
            state_next.ovr_out = smp.over | state_reg.held.over;
            state_next.owc     = 1'b1;
            state_next.phase   = 2'h3;
            irq_set[adc_split_pkg::IRQ_OVERRANGE_BIT] = smp.over | state_reg.held.over;
          end else begin
            // Phases 1 and 3 discard their sample.
            state_next.phase = state_reg.phase + 2'h1;
          end
        end
      endcase
    end

    // Write address and data are taken independently.
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_held = 1'b1;
      state_next.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_held = 1'b1;
      state_next.wdata  = s_axi_wdata;
      state_next.wstrb  = s_axi_wstrb;
    end
    // Both halves present: perform the write and answer.
    do_write = state_reg.aw_held & state_reg.w_held & ~state_reg.bvalid;
    if (do_write) begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = adc_split_pkg::RESP_OKAY;
      unique case (state_reg.awaddr)
        adc_split_pkg::CTRL_OFFSET: begin
          if (state_reg.wstrb[0]) begin
            state_next.ctrl = state_reg.wdata[adc_split_pkg::CTRL_WIDTH-1:0];
          end
        end
        adc_split_pkg::IRQ_STATUS_OFFSET: begin
          if (state_reg.wstrb[0]) begin
            irq_clr = state_reg.wdata[adc_split_pkg::IRQ_WIDTH-1:0];
          end
        end
        adc_split_pkg::IRQ_MASK_OFFSET: begin
          if (state_reg.wstrb[0]) begin
            state_next.irq_mask = state_reg.wdata[adc_split_pkg::IRQ_WIDTH-1:0];
          end
        end
        adc_split_pkg::STATUS_OFFSET, adc_split_pkg::DATA_OFFSET: begin
          // Read-only registers ignore the write.
          state_next.bresp = adc_split_pkg::RESP_OKAY;
        end
        default: begin
          state_next.bresp = adc_split_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    state_next.irq_status = (state_reg.irq_status & ~irq_clr) | irq_set;

    // Reads are answered one cycle after the address is taken.
    if (s_axi_arvalid && s_axi_arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = adc_split_pkg::RESP_OKAY;
      state_next.rdata  = 32'h00000000;
      unique case (s_axi_araddr)
        adc_split_pkg::CTRL_OFFSET: begin
          state_next.rdata[adc_split_pkg::CTRL_WIDTH-1:0] = state_reg.ctrl;
        end
        adc_split_pkg::STATUS_OFFSET: begin
          state_next.rdata[7:0] = {sec_powered, state_reg.rst_out, state_reg.ovr_out,
                                   state_reg.owc, state_reg.phase, mode};
        end
        adc_split_pkg::IRQ_STATUS_OFFSET: begin
          state_next.rdata[adc_split_pkg::IRQ_WIDTH-1:0] = state_reg.irq_status;
        end
        adc_split_pkg::IRQ_MASK_OFFSET: begin
          state_next.rdata[adc_split_pkg::IRQ_WIDTH-1:0] = state_reg.irq_mask;
        end
        adc_split_pkg::DATA_OFFSET: begin
          state_next.rdata[17:0] = {state_reg.sec.over, state_reg.prim.over,
                                    state_reg.sec.code, state_reg.prim.code};
        end
        default: begin
          state_next.rresp = adc_split_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg          <= '0;
      state_reg.ctrl     <= adc_split_pkg::CTRL_RESET;
      state_reg.irq_mask <= adc_split_pkg::IRQ_MASK_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bus handshakes and port drivers.
  always_comb begin
    s_axi_awready = ~state_reg.aw_held & ~state_reg.bvalid;
    s_axi_wready  = ~state_reg.w_held & ~state_reg.bvalid;
    s_axi_bvalid  = state_reg.bvalid;
    s_axi_bresp   = state_reg.bresp;
    s_axi_arready = ~state_reg.rvalid;
    s_axi_rvalid  = state_reg.rvalid;
    s_axi_rdata   = state_reg.rdata;
    s_axi_rresp   = state_reg.rresp;
    // RULE2 offset binary outputs
    primary_data_p      = state_reg.prim.code;
    primary_data_n      = ~state_reg.prim.code;
    // RULE9 unpowered lines rest high
    secondary_data_p    = sec_powered ? state_reg.sec.code : 8'hFF;
    secondary_data_n    = sec_powered ? ~state_reg.sec.code : 8'hFF;
    output_word_clock_p = state_reg.owc;
    output_word_clock_n = ~state_reg.owc;
    overrange_p         = state_reg.ovr_out;
    overrange_n         = ~state_reg.ovr_out;
    split_reset_out_p   = state_reg.rst_out;
    split_reset_out_n   = ~state_reg.rst_out;
    irq                 = |(state_reg.irq_status & state_reg.irq_mask);
  end

endmodule : adc_output_demux

`default_nettype wire

// [hdl/adc_split_pkg.sv]
package adc_split_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] CTRL_OFFSET       = 8'h00;
  localparam logic [7:0] STATUS_OFFSET     = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h0C;
  localparam logic [7:0] DATA_OFFSET       = 8'h10;

  // Control register field positions.
  localparam int CTRL_SPLIT_ENABLE_BIT = 0;
  localparam int CTRL_RATE_SELECT_BIT  = 1;
  localparam int CTRL_POWER_A_BIT      = 2;
  localparam int CTRL_POWER_B_BIT      = 3;
  localparam int CTRL_SOFT_RESET_BIT   = 4;
  localparam int CTRL_WIDTH            = 5;

  // Interrupt event bit positions.
  localparam int IRQ_OVERRANGE_BIT = 0;
  localparam int IRQ_RESET_BIT     = 1;
  localparam int IRQ_WIDTH         = 2;

  // Reset values: splitter off, secondary port powered, no interrupts enabled.
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET     = 5'h0C;
  localparam logic [IRQ_WIDTH-1:0]  IRQ_MASK_RESET = 2'h0;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sample width and the number of comparator levels feeding the encoder.
  localparam int CODE_WIDTH = 8;
  localparam int LEVELS     = 255;

  // Output splitter modes, Gray coded.
  typedef enum logic [1:0] {
    SINGLE_PORT_MODE = 2'h0,
    DUAL_PORT_MODE   = 2'h1,
    DECIMATED_MODE   = 2'h3
  } split_mode_t;

  // Software control bits.
  typedef struct packed {
    logic soft_reset;
    logic power_b;
    logic power_a;
    logic rate_select;
    logic split_enable;
  } ctrl_t;

  // One converted sample with its overrange flag.
  typedef struct packed {
    logic                  over;
    logic [CODE_WIDTH-1:0] code;
  } sample_t;

endpackage : adc_split_pkg

// [hdl/thermo_encoder.sv]
`timescale 1ns/1ps
`default_nettype none

// Turns a comparator thermometer pattern into an offset-binary code.
// Counting the ones rather than locating the top transition means a stray
// bubble moves the result by one step at most, never to full or zero scale.
module thermo_encoder #(
  parameter int LEVELS = adc_split_pkg::LEVELS,
  parameter int WIDTH  = adc_split_pkg::CODE_WIDTH
) (
  input  wire logic [LEVELS-1:0] levels,   // Comparator outputs, level 0 lowest.
  output logic      [WIDTH-1:0]  code      // Offset binary result.
);

  // Population count of the thermometer.
  always_comb begin
    logic [WIDTH-1:0] count;
    count = '0;
    // RULE11 bubble tolerant count
    for (int i = 0; i < LEVELS; i++) begin
      count = count + WIDTH'(levels[i]);
    end
    // RULE2 zero is most negative
    code = count;
  end

endmodule : thermo_encoder

`default_nettype wire

// [tb/adc_output_demux_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the output port and the read channel of the splitter.
module adc_output_demux_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic       sample_clock,
  input wire logic [7:0] primary_data_p,
  input wire logic [7:0] primary_data_n,
  input wire logic [7:0] secondary_data_p,
  input wire logic [7:0] secondary_data_n,
  input wire logic       output_word_clock_p,
  input wire logic       output_word_clock_n,
  input wire logic       overrange_p,
  input wire logic       overrange_n,
  input wire logic       split_reset_out_p,
  input wire logic       split_reset_out_n
);
  default clocking dclk @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic       sclk_q; // Sample clock one edge ago.
  logic [3:0] since;  // Edges since the sample clock rose.
  // Counts how old the latest sample edge is, saturating at 15.
  always_ff @(posedge aclk) begin
    sclk_q <= sample_clock;
    if (!aresetn || (sample_clock && !sclk_q)) since <= 4'h0;
    else if (since != 4'hF) since <= since + 4'h1;
  end
  a_prim_pair: assert property (primary_data_n == ~primary_data_p)
    else $error("primary pair not complementary");
  a_sec_pair: assert property ((secondary_data_n == ~secondary_data_p) ||
    (secondary_data_p == 8'hFF && secondary_data_n == 8'hFF)) else $error("secondary pair broken");
  a_flag_pairs: assert property (output_word_clock_n == ~output_word_clock_p &&
    overrange_n == ~overrange_p && split_reset_out_n == ~split_reset_out_p) else $error("flag pair broken");
  a_data_on_wclk: assert property (!$stable(primary_data_p) |-> $rose(output_word_clock_p))
    else $error("primary word moved without word clock");
  a_over_on_wclk: assert property (!$stable(overrange_p) |-> $rose(output_word_clock_p))
    else $error("overrange moved without word clock");
  a_wclk_latency: assert property ($rose(output_word_clock_p) |-> since <= 4'h4)
    else $error("word clock not caused by a sample edge");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule : adc_output_demux_asserts
bind adc_output_demux adc_output_demux_asserts u_asserts (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sample_clock, .primary_data_p, .primary_data_n,
  .secondary_data_p, .secondary_data_n, .output_word_clock_p, .output_word_clock_n, .overrange_p,
  .overrange_n, .split_reset_out_p, .split_reset_out_n);
`default_nettype wire

// [tb/adc_output_demux_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// Runs the splitter through its modes and checks what reaches the receiver.
module adc_output_demux_tb;
  // Control bits, reset by pin, three samples {over,code}, expected last word and word count.
  typedef struct packed {
    logic [3:0] ctrl;
    logic       pin;
    logic [8:0] s0, s1, s2;
    logic [7:0] ep, es;
    logic       eo;
    logic [1:0] en;
  } row_t;
  localparam row_t rows [6] = '{
    '{4'hC, 1'b0, 9'h000, 9'h17F, 9'h080, 8'h80, 8'h7F, 1'b0, 2'h2},
    '{4'hE, 1'b1, 9'h011, 9'h0FF, 9'h100, 8'h00, 8'hFF, 1'b1, 2'h2},
    '{4'hD, 1'b0, 9'h1A5, 9'h05A, 9'h033, 8'h5A, 8'hA5, 1'b1, 2'h1},
    '{4'hD, 1'b1, 9'h001, 9'h0FE, 9'h1FF, 8'hFE, 8'h01, 1'b0, 2'h1},
    '{4'hF, 1'b0, 9'h0C3, 9'h1AA, 9'h03C, 8'h3C, 8'hC3, 1'b0, 2'h1},
    '{4'hF, 1'b1, 9'h010, 9'h020, 9'h1F0, 8'hF0, 8'h10, 1'b1, 2'h1}};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sample_clock, comparator_over;
  logic split_reset_in, output_word_clock_p, output_word_clock_n, overrange_p, overrange_n;
  logic split_reset_out_p, split_reset_out_n, irq, cap_over, cap_bad;
  logic [7:0] s_axi_awaddr, s_axi_araddr, primary_data_p, primary_data_n, secondary_data_p, secondary_data_n;
  logic [7:0] cap_prim, cap_sec;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [254:0] comparator_levels;
  logic [15:0] cap_count, n0;
  int miscompares, cmp_count, cycles;
  adc_output_demux dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_clock,
    .comparator_levels, .comparator_over, .split_reset_in, .primary_data_p, .primary_data_n, .secondary_data_p,
    .secondary_data_n, .output_word_clock_p, .output_word_clock_n, .overrange_p, .overrange_n,
    .split_reset_out_p, .split_reset_out_n, .irq);
  word_capture u_cap (.aclk, .primary_data_p, .primary_data_n, .secondary_data_p, .output_word_clock_p,
    .overrange_p, .cap_prim, .cap_sec, .cap_over, .cap_count, .cap_bad);
  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // Write: both halves offered together, each dropped once taken; bready stays high.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
    logic aw_hs, w_hs, b_hs;
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end while (!b_hs);
  endtask : axi_write
  // Read: rready is raised one edge after the address is taken, so the slave must hold its answer.
  task automatic axi_read(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
    logic ar_hs, ar_done, r_hs;
    ar_done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid && s_axi_rready;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (ar_done && !r_hs) s_axi_rready <= 1'b1;
      ar_done = ar_done || ar_hs;
    end while (!r_hs);
    s_axi_rready <= 1'b0;
  endtask : axi_read
  // One sample: levels settle 4 edges before the sample clock rises, clock period 8 edges.
  task automatic send(input logic [254:0] lv, input logic ov);
    comparator_levels <= lv;
    comparator_over <= ov;
    repeat (4) @(posedge aclk);
    sample_clock <= 1'b1;
    repeat (4) @(posedge aclk);
    sample_clock <= 1'b0;
  endtask : send
  function automatic logic [254:0] thermo(input logic [7:0] c);
    thermo = {255{1'b1}} >> (9'd255 - {1'b0, c});
  endfunction : thermo
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Cuts a hang short.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      close_out;
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_rready, sample_clock} = 6'h00;
    {comparator_over, split_reset_in, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {comparator_levels, miscompares, cmp_count, cycles} = '0;
    s_axi_bready = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axi_read(adc_split_pkg::CTRL_OFFSET, d, r);
    chk(d, {27'h0, adc_split_pkg::CTRL_RESET});
    // Each row: phase reset with the first sample, then two more samples in the chosen mode.
    for (int i = 0; i < 6; i++) begin
      axi_write(adc_split_pkg::CTRL_OFFSET, {27'h0, !rows[i].pin, rows[i].ctrl}, r);
      split_reset_in <= rows[i].pin;
      send(thermo(rows[i].s0[7:0]), rows[i].s0[8]);
      split_reset_in <= 1'b0;
      @(negedge aclk);
      chk({31'h0, split_reset_out_p}, 32'h1);
      @(posedge aclk);
      axi_write(adc_split_pkg::CTRL_OFFSET, {28'h0, rows[i].ctrl}, r);
      n0 = cap_count;
      send(thermo(rows[i].s1[7:0]), rows[i].s1[8]);
      send(thermo(rows[i].s2[7:0]), rows[i].s2[8]);
      @(negedge aclk);
      chk({24'h0, cap_prim}, {24'h0, rows[i].ep});
      chk({24'h0, cap_sec}, {24'h0, rows[i].es});
      chk({31'h0, cap_over}, {31'h0, rows[i].eo});
      chk({16'h0, cap_count - n0}, {30'h0, rows[i].en});
      chk({31'h0, split_reset_out_p}, 32'h0);
      @(posedge aclk);
    end
    axi_write(adc_split_pkg::CTRL_OFFSET, 32'h0, r);
    @(posedge aclk);
    @(negedge aclk);
    chk({16'h0, secondary_data_p, secondary_data_n}, 32'hFFFF);
    @(posedge aclk);
    send(thermo(8'h40) ^ ((255'h1 << 10) | (255'h1 << 100)), 1'b0);
    @(negedge aclk);
    chk({31'h0, primary_data_p >= 8'h3F && primary_data_p <= 8'h41}, 32'h1);
    chk({31'h0, cap_bad}, 32'h0);
    @(posedge aclk);
    axi_read(adc_split_pkg::DATA_OFFSET, d, r);
    chk(d, 32'h0002F040);
    axi_read(adc_split_pkg::IRQ_STATUS_OFFSET, d, r);
    chk(d, 32'h3);
    chk({31'h0, irq}, 32'h0);
    axi_write(adc_split_pkg::IRQ_MASK_OFFSET, 32'h1, r);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h1);
    @(posedge aclk);
    axi_write(adc_split_pkg::IRQ_STATUS_OFFSET, 32'h3, r);
    axi_read(adc_split_pkg::IRQ_STATUS_OFFSET, d, r);
    chk(d, 32'h0);
    chk({31'h0, irq}, 32'h0);
    axi_read(8'h20, d, r);
    chk({d[29:0], r}, {30'h0, adc_split_pkg::RESP_SLVERR});
    axi_write(8'h24, 32'h1, r);
    chk({30'h0, r}, {30'h0, adc_split_pkg::RESP_SLVERR});
    close_out;
  end
endmodule : adc_output_demux_tb
`default_nettype wire

// [tb/word_capture.sv]
`timescale 1ns/1ps
`default_nettype none
// Receiver model: latches each word one clock after the word clock rises.
module word_capture (
  input wire logic        aclk,
  input wire logic [7:0]  primary_data_p,
  input wire logic [7:0]  primary_data_n,
  input wire logic [7:0]  secondary_data_p,
  input wire logic        output_word_clock_p,
  input wire logic        overrange_p,
  output logic     [7:0]  cap_prim,
  output logic     [7:0]  cap_sec,
  output logic            cap_over,
  output logic     [15:0] cap_count,
  output logic            cap_bad
);
  logic wclk_q; // Word clock one edge ago.
  initial begin
    wclk_q = 1'b0;
    cap_count = 16'h0;
    cap_bad = 1'b0;
  end
  // Capture on the word clock rising, and note a broken primary pair.
  always @(posedge aclk) begin
    wclk_q <= output_word_clock_p;
    if (output_word_clock_p && !wclk_q) begin
      cap_prim <= primary_data_p;
      cap_sec <= secondary_data_p;
      cap_over <= overrange_p;
      cap_count <= cap_count + 16'h1;
      if (primary_data_n !== ~primary_data_p) cap_bad <= 1'b1;
    end
  end
endmodule : word_capture
`default_nettype wire
